// file: rtl/wd_supervisor_pkg.sv
// Constants for the dual-window watchdog supervisor
package wd_supervisor_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_DIV = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICK_W = 18;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned LONG_WINDOW_MS = 35000;
  localparam int unsigned SHORT_WINDOW_MS = 1120;
  localparam int unsigned HOLD_TIME_MS = 140;
  localparam int unsigned LONG_TICKS = LONG_WINDOW_MS * 1000 / TICK_US;
  localparam int unsigned SHORT_TICKS = SHORT_WINDOW_MS * 1000 / TICK_US;
  localparam int unsigned HOLD_TICKS = HOLD_TIME_MS * 1000 / TICK_US;
endpackage

// file: rtl/wd_tick_gen.sv
// Free-running tick divider for all supervisor windows
`timescale 1ns/1ps
module wd_tick_gen #(
  parameter int unsigned DIV = wd_supervisor_pkg::TICK_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  output logic tick
);
  logic [wd_supervisor_pkg::TICK_W-1:0] div_q;
  wire div_end = (div_q == wd_supervisor_pkg::TICK_W'(DIV - 1));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
      tick <= 1'b0;
    end else begin
      div_q <= div_end ? '0 : div_q + 1'b1;
      tick <= div_end;
    end
  end
endmodule

// file: rtl/dual_window_watchdog_supervisor.sv
// Watchdog with long startup and short service windows plus reset hold
`timescale 1ns/1ps
// What this block does
// - Any rising or falling service edge restarts the watchdog count.
// - Fault output goes low when service input stays static past window.
// - No disable state; a static input still times out.
// - After each reset event the first window is long, 35 s.
// - Short 1.12 s window starts after long window or first edge.
// - In normal mode, missing edge within short window raises fault.
// - Fault into manual reset asserts reset, clears count, releases fault.
// - After watchdog reset, count restarts in long mode at hold end.
// - Manual reset low asserts reset, clears count, releases fault.
// - Reset held while manual reset low and hold period after release.
// - Recurring undervoltage during hold restarts the hold timer.
module dual_window_watchdog_supervisor #(
  parameter int unsigned TICK_DIV = wd_supervisor_pkg::TICK_DIV,
  parameter int unsigned LONG_TICKS = wd_supervisor_pkg::LONG_TICKS,
  parameter int unsigned SHORT_TICKS = wd_supervisor_pkg::SHORT_TICKS,
  parameter int unsigned HOLD_TICKS = wd_supervisor_pkg::HOLD_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic watchdog_service_in,
  input wire logic manual_reset_n,
  input wire logic [2:0] undervoltage,
  output logic watchdog_fault_n,
  output logic reset_out_n,
  output logic long_mode
);
  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_LONG = 3'h2,
    ST_SHORT = 3'h4
  } wd_state_e;

  wd_state_e state_q, state_d;
  logic tick;
  logic svc_q;
  logic [wd_supervisor_pkg::CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic [wd_supervisor_pkg::CNT_W-1:0] hold_cnt_q, hold_cnt_d;

  function automatic logic reached(input logic [wd_supervisor_pkg::CNT_W-1:0] cnt, input int unsigned lim);
    reached = (cnt >= wd_supervisor_pkg::CNT_W'(lim - 1));
  endfunction

  wd_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tick(tick)
  );

  wire reset_cause = !manual_reset_n || (|undervoltage);
  wire edge_seen = watchdog_service_in ^ svc_q;
  wire hold_done = tick && reached(hold_cnt_q, HOLD_TICKS);
  wire win_done = tick && reached(wd_cnt_q, (state_q == ST_LONG) ? LONG_TICKS : SHORT_TICKS);
  wire fault_now = (state_q != ST_HOLD) && !edge_seen && win_done && !reset_cause;

  always_comb begin
    state_d = state_q;
    wd_cnt_d = wd_cnt_q;
    hold_cnt_d = hold_cnt_q;
    if (reset_cause) begin
      state_d = ST_HOLD;
      wd_cnt_d = '0;
      hold_cnt_d = '0;
    end else begin
      unique case (state_q)
        ST_HOLD: begin
          wd_cnt_d = '0;
          if (hold_done) begin
            state_d = ST_LONG;
            hold_cnt_d = '0;
          end else if (tick) begin
            hold_cnt_d = hold_cnt_q + 1'b1;
          end
        end
        ST_LONG, ST_SHORT: begin
          if (edge_seen) begin
            state_d = ST_SHORT;
            wd_cnt_d = '0;
          end else if (win_done) begin
            state_d = ST_SHORT;
            wd_cnt_d = '0;
          end else if (tick) begin
            wd_cnt_d = wd_cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_HOLD;
      wd_cnt_q <= '0;
      hold_cnt_q <= '0;
      svc_q <= 1'b0;
      watchdog_fault_n <= 1'b1;
      reset_out_n <= 1'b0;
      long_mode <= 1'b0;
    end else begin
      state_q <= state_d;
      wd_cnt_q <= wd_cnt_d;
      hold_cnt_q <= hold_cnt_d;
      svc_q <= watchdog_service_in;
      reset_out_n <= (state_d != ST_HOLD);
      long_mode <= (state_d == ST_LONG);
      if (reset_cause || edge_seen) begin
        watchdog_fault_n <= 1'b1;
      end else if (fault_now) begin
        watchdog_fault_n <= 1'b0;
      end
    end
  end

  property p_rst_on_cause;
    @(posedge clk_sys) disable iff (!rst_b) reset_cause |=> !reset_out_n;
  endproperty
  a_rst_on_cause: assert property (p_rst_on_cause) else $error("reset not asserted");

  property p_fault_release;
    @(posedge clk_sys) disable iff (!rst_b) reset_cause |=> watchdog_fault_n;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault not released");

  property p_edge_clears;
    @(posedge clk_sys) disable iff (!rst_b) (edge_seen && !reset_cause && state_q != ST_HOLD) |=> wd_cnt_q == '0;
  endproperty
  a_edge_clears: assert property (p_edge_clears) else $error("edge did not clear count");

  property p_edge_short;
    @(posedge clk_sys) disable iff (!rst_b) (edge_seen && !reset_cause && state_q == ST_LONG) |=> state_q == ST_SHORT;
  endproperty
  a_edge_short: assert property (p_edge_short) else $error("no switch to short window");

  property p_hold_to_long;
    @(posedge clk_sys) disable iff (!rst_b) (state_q == ST_HOLD && hold_done && !reset_cause) |=> long_mode && reset_out_n;
  endproperty
  a_hold_to_long: assert property (p_hold_to_long) else $error("no long window after hold");

  property p_fault_cause;
    @(posedge clk_sys) disable iff (!rst_b) $fell(watchdog_fault_n) |-> $past(win_done) && !$past(edge_seen);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without timeout");

  property p_timeout_fault;
    @(posedge clk_sys) disable iff (!rst_b) fault_now |=> !watchdog_fault_n;
  endproperty
  a_timeout_fault: assert property (p_timeout_fault) else $error("timeout did not fault");

  property p_hold_restart;
    @(posedge clk_sys) disable iff (!rst_b) (|undervoltage) |=> hold_cnt_q == '0 && !reset_out_n;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("hold not restarted");

  property p_long_no_early;
    @(posedge clk_sys) disable iff (!rst_b) (state_q == ST_LONG && !reached(wd_cnt_q, LONG_TICKS)) |=> watchdog_fault_n;
  endproperty
  a_long_no_early: assert property (p_long_no_early) else $error("early fault in long window");

  property p_hold_no_fault;
    @(posedge clk_sys) disable iff (!rst_b) state_q == ST_HOLD |-> watchdog_fault_n;
  endproperty
  a_hold_no_fault: assert property (p_hold_no_fault) else $error("fault low during hold");

  property p_hold_out;
    @(posedge clk_sys) disable iff (!rst_b) (state_q == ST_HOLD) |-> !reset_out_n;
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("reset released during hold");

  property p_mode_out;
    @(posedge clk_sys) disable iff (!rst_b) long_mode == (state_q == ST_LONG);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("long mode flag wrong");

  property p_cause_clears;
    @(posedge clk_sys) disable iff (!rst_b) reset_cause |=> wd_cnt_q == '0;
  endproperty
  a_cause_clears: assert property (p_cause_clears) else $error("count not cleared by reset");

  property p_cause_holds;
    @(posedge clk_sys) disable iff (!rst_b) reset_cause |=> state_q == ST_HOLD;
  endproperty
  a_cause_holds: assert property (p_cause_holds) else $error("no hold on reset cause");

  property p_hold_stays;
    @(posedge clk_sys) disable iff (!rst_b) (state_q == ST_HOLD && !hold_done) |=> state_q == ST_HOLD;
  endproperty
  a_hold_stays: assert property (p_hold_stays) else $error("hold left early");

  property p_expiry_short;
    @(posedge clk_sys) disable iff (!rst_b) (state_q == ST_LONG && win_done && !reset_cause) |=> state_q == ST_SHORT;
  endproperty
  a_expiry_short: assert property (p_expiry_short) else $error("no short window after expiry");

  property p_short_no_early;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_q == ST_SHORT && !reached(wd_cnt_q, SHORT_TICKS) && watchdog_fault_n) |=> watchdog_fault_n;
  endproperty
  a_short_no_early: assert property (p_short_no_early) else $error("early fault in short window");

  property p_count_bounded;
    @(posedge clk_sys) disable iff (!rst_b) (state_q != ST_HOLD) |-> wd_cnt_q < LONG_TICKS;
  endproperty
  a_count_bounded: assert property (p_count_bounded) else $error("count ran past window");

  property p_tick_advances;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_q != ST_HOLD && tick && !edge_seen && !win_done && !reset_cause) |=> wd_cnt_q == $past(wd_cnt_q) + 1'b1;
  endproperty
  a_tick_advances: assert property (p_tick_advances) else $error("count did not advance on tick");

  property p_fault_kept;
    @(posedge clk_sys) disable iff (!rst_b) (!watchdog_fault_n && !edge_seen && !reset_cause) |=> !watchdog_fault_n;
  endproperty
  a_fault_kept: assert property (p_fault_kept) else $error("fault dropped without service");

  c_fault: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(watchdog_fault_n));
  c_edge_short: cover property (@(posedge clk_sys) disable iff (!rst_b) state_q == ST_SHORT && edge_seen);
  c_hold_again: cover property (@(posedge clk_sys) disable iff (!rst_b) state_q == ST_HOLD && (|undervoltage));
  c_short: cover property (@(posedge clk_sys) disable iff (!rst_b) state_q == ST_LONG ##1 state_q == ST_SHORT);
  c_release: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(reset_out_n));
endmodule

// file: verif/wd_service_host.sv
// Processor model that services the watchdog by level changes
`timescale 1ns/1ps
module wd_service_host (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic kick,
  input wire logic [4:0] gap,
  output logic watchdog_service_in
);
  int cnt = 0;
  initial watchdog_service_in = 1'b0;
  // Level is set and cleared at separate points, never pulsed
  always @(posedge clk_sys) begin
    cnt <= run ? cnt + 1 : 0;
    if (kick || (run && cnt >= gap)) begin
      cnt <= 0;
      watchdog_service_in <= !watchdog_service_in;
    end
  end
endmodule

// file: verif/dual_window_watchdog_supervisor_tb.sv
// Self-checking bench for the dual-window watchdog supervisor
`timescale 1ns/1ps
module dual_window_watchdog_supervisor_tb;
  localparam int D = 4, L = 20, S = 5, H = 3;
  logic clk_sys = 1'b0, rst_b = 1'b0, manual_reset_n = 1'b1, tie = 1'b0;
  logic run = 1'b0, kick = 1'b0, svc, watchdog_fault_n, reset_out_n, long_mode;
  logic [2:0] undervoltage = 3'h0;
  logic [4:0] gap = 5'h8;
  int mismatches = 0, check_count = 0, n;
  always #2.5 clk_sys = !clk_sys;
  always @(posedge clk_sys) manual_reset_n <= tie ? watchdog_fault_n : 1'b1;
  wd_service_host i_host (.clk_sys(clk_sys), .run(run), .kick(kick), .gap(gap), .watchdog_service_in(svc));
  dual_window_watchdog_supervisor #(.TICK_DIV(D), .LONG_TICKS(L), .SHORT_TICKS(S), .HOLD_TICKS(H)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .watchdog_service_in(svc), .manual_reset_n(manual_reset_n),
    .undervoltage(undervoltage), .watchdog_fault_n(watchdog_fault_n), .reset_out_n(reset_out_n),
    .long_mode(long_mode));
  task automatic end_of_test();
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic s, input logic e, input string nm);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    for (k = 0; s !== v && k < lim; k++) @(negedge clk_sys);
    if (k == lim) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic pulse_kick();
    @(posedge clk_sys) kick <= 1'b1;
    @(posedge clk_sys) kick <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h2AA1765E));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_lvl(reset_out_n, 1'b1, 40, n);
    chk(n >= (H - 1) * D && n <= (H + 1) * D + 2, 1'b1, "hold");
    chk(long_mode, 1'b1, "long_mode");
    wait_lvl(watchdog_fault_n, 1'b0, 200, n);
    chk(n >= (L - 1) * D && n <= (L + 1) * D + 2, 1'b1, "long_win");
    chk(long_mode, 1'b0, "short_mode");
    pulse_kick();
    repeat (2) @(negedge clk_sys);
    chk(watchdog_fault_n, 1'b1, "fault_clr");
    @(posedge clk_sys);
    gap <= 5'($urandom_range(6, 11));
    run <= 1'b1;
    repeat (150) @(negedge clk_sys) chk(watchdog_fault_n, 1'b1, "serviced");
    @(posedge clk_sys);
    run <= 1'b0;
    wait_lvl(watchdog_fault_n, 1'b0, 60, n);
    chk(n <= (S + 1) * D + 2, 1'b1, "short_win");
    @(posedge clk_sys);
    tie <= 1'b1;
    wait_lvl(reset_out_n, 1'b0, 4, n);
    repeat (2) @(negedge clk_sys);
    chk(watchdog_fault_n, 1'b1, "fault_rel");
    chk(long_mode, 1'b0, "hold_mode");
    pulse_kick();
    wait_lvl(reset_out_n, 1'b1, 30, n);
    @(posedge clk_sys);
    tie <= 1'b0;
    chk(long_mode, 1'b1, "relong");
    @(posedge clk_sys) undervoltage <= 3'(1 << $urandom_range(0, 2));
    @(posedge clk_sys) undervoltage <= 3'h0;
    repeat (8) @(posedge clk_sys);
    undervoltage <= 3'h4;
    @(posedge clk_sys) undervoltage <= 3'h0;
    wait_lvl(reset_out_n, 1'b1, 30, n);
    chk(n >= (H - 1) * D, 1'b1, "rehold");
    end_of_test();
  end
endmodule
